// ### design/stepper_index_velocity_and_fault_logic.sv
/*
 * Digital side of a two-phase stepper driver: position marker output,
 * internal velocity step generator, step period measurement, heat shutdown
 * latch and bridge short protection, with an AXI4-Lite register slave.
 * Assumes pin inputs are asynchronous to aclk and that analog comparators
 * and short detectors deliver plain levels on the pin record.
 */
// Chosen here: the AXI4-Lite register port and the register offsets.
// How it works
// - Marker fires at coil A positive zero
// - Default marker once per electrical period
// - Generator runs written velocity, no ramping
// - Velocity is signed; sign gives direction
// - Rate is velocity times clock/2/2^23
// - Measure clocks between steps as period
// - Step-toggle option toggles marker per step
// - Position counter wraps 1023 to 0
// - Prewarn and shutdown thresholds are selectable
// - Default shutdown 143C, prewarn 120C
// - 150C shutdown by OTP or serial
// - 157C shutdown only by serial setting
// - Shutdown latched until below prewarn level
// - Ground, supply shorts and undervoltage flagged apart
// - Short confirmed after three retries
// - Only the shorted bridge switches off
`timescale 1ns/100ps
`default_nettype none

module stepper_index_velocity_and_fault_logic
    import stepper_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire pins_s pins,
    input wire logic [1:0] otp_temp_sel,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic index_out,
    output logic bridge_a_enable,
    output logic bridge_b_enable,
    output logic irq
);

    state_s q;
    state_s d;

    // ------
    // Combinational next state
    // ------
    always_comb begin
        logic [PIN_W-1:0] agreed;
        pins_s p;
        logic step_rise;
        logic [23:0] vel_abs;
        logic [23:0] acc_sum;
        logic gen_step;
        logic gen_active;
        logic do_step;
        logic step_down;
        logic [1:0] tsel;
        logic prewarn;
        logic shutdown;
        logic driver_en;
        logic [3:0] short_raw;
        logic [3:0] short_prev;
        logic [3:0] short_confirm;
        logic [7:0] events;
        logic wr_fire;
        logic [7:0] wclear;
        logic ok;
        logic [31:0] rd;

        d = q;
        agreed = '0;
        p = q.pins_q;
        step_rise = 1'b0;
        vel_abs = '0;
        acc_sum = '0;
        gen_step = 1'b0;
        gen_active = 1'b0;
        do_step = 1'b0;
        step_down = 1'b0;
        tsel = TSEL_143_PW120;
        prewarn = 1'b0;
        shutdown = 1'b0;
        driver_en = 1'b0;
        short_raw = '0;
        short_prev = '0;
        short_confirm = '0;
        events = '0;
        wr_fire = 1'b0;
        wclear = '0;
        ok = 1'b0;
        rd = '0;

        // ------
        // Pin synchronisers: a change counts once stages two and three agree
        // ------
        d.sync1_q = pins;
        d.sync2_q = q.sync1_q;
        d.sync3_q = q.sync2_q;
        for (int i = 0; i < PIN_W; i++) begin
            agreed[i] = (q.sync2_q[i] == q.sync3_q[i]) ? q.sync3_q[i] : p[i];
        end
        d.pins_q = pins_s'(agreed);
        step_rise = d.pins_q.step & ~q.pins_q.step;

        // OTP setting is caught once, on the first edge after reset release
        if (!q.otp_taken_q) begin
            d.otp_taken_q = 1'b1;
            d.otp_sel_q = otp_temp_sel;
        end

        // ------
        // Internal step generator
        // ------
        // Sign bit picks the direction; magnitude feeds the accumulator
        gen_active = (q.generator_velocity_q != VELOCITY_RESET);
        vel_abs = q.generator_velocity_q[23] ? 24'(-q.generator_velocity_q)
                                             : q.generator_velocity_q;
        // Accumulate on every other clock, so one unit is fclk/2/2^23
        d.half_tick_q = ~q.half_tick_q;
        if (gen_active && q.half_tick_q) begin
            acc_sum = {1'b0, q.phase_acc_q} + vel_abs;
            d.phase_acc_q = acc_sum[22:0];
            gen_step = acc_sum[23];
        end
        if (!gen_active) begin
            d.phase_acc_q = '0;
        end

        // Velocity is applied as written; any ramp is the host's job
        if (gen_active) begin
            do_step = gen_step;
            step_down = q.generator_velocity_q[23];
        end else begin
            do_step = step_rise;
            step_down = q.pins_q.dir;
        end

        // Natural 10-bit wrap gives 1023 -> 0 and 0 -> 1023
        if (do_step) begin
            d.microstep_position_count_q = step_down ? q.microstep_position_count_q - 10'h001
                                                     : q.microstep_position_count_q + 10'h001;
        end

        // ------
        // Step period measurement; the count saturates when motion stops, the register holds the last period
        // ------
        if (do_step) begin
            d.measured_step_period_q = (q.period_cnt_q == PERIOD_MAX) ? PERIOD_MAX
                                                                     : q.period_cnt_q + 20'h00001;
            d.period_cnt_q = '0;
        end else if (q.period_cnt_q != PERIOD_MAX) begin
            d.period_cnt_q = q.period_cnt_q + 20'h00001;
        end

        // ------
        // Position marker
        // ------
        if (q.global_config_q[CFG_INDEX_STEP]) begin
            d.index_q = q.index_q ^ do_step;
        end else begin
            // Table position zero is coil A's rising zero crossing
            d.index_q = (d.microstep_position_count_q == MSCOUNT_RESET);
        end
        events[EV_INDEX] = do_step && (d.microstep_position_count_q == MSCOUNT_RESET);

        // ------
        // Temperature thresholds and shutdown latch
        // ------
        // Serial setting may pick 157C; the OTP code 3 falls back to default
        if (q.global_config_q[CFG_TEMP_SERIAL]) begin
            tsel = q.global_config_q[CFG_TEMP_SEL_LO +: 2];
        end else if (q.otp_sel_q != TSEL_157_PW143) begin
            tsel = q.otp_sel_q;
        end else begin
            tsel = TSEL_143_PW120;
        end
        unique case (tsel)
            TSEL_143_PW120: begin
                shutdown = p.temp_above[T143];
                prewarn = p.temp_above[T120];
            end
            TSEL_150_PW120: begin
                shutdown = p.temp_above[T150];
                prewarn = p.temp_above[T120];
            end
            TSEL_150_PW143: begin
                shutdown = p.temp_above[T150];
                prewarn = p.temp_above[T143];
            end
            TSEL_157_PW143: begin
                shutdown = p.temp_above[T157];
                prewarn = p.temp_above[T143];
            end
        endcase
        // Set wins over the release so a fresh trip is never missed
        if (shutdown) begin
            d.heat_shutdown_flag_q = 1'b1;
        end else if (!prewarn) begin
            d.heat_shutdown_flag_q = 1'b0;
        end
        events[EV_SHUTDOWN] = shutdown & ~q.heat_shutdown_flag_q;
        events[EV_PREWARN] = prewarn & ~(q.pins_q.temp_above != d.pins_q.temp_above ? 1'b0 : 1'b1);

        // ------
        // Short protection with retries
        // ------
        driver_en = q.global_config_q[CFG_DRIVER_ENABLE];
        short_raw = {d.pins_q.supply_short, d.pins_q.ground_short};
        short_prev = {q.pins_q.supply_short, q.pins_q.ground_short};
        for (int i = 0; i < 4; i++) begin
            if (!driver_en) begin
                // Disabling the driver, or a reset, is the only way to rearm a bridge
                d.short_flag_q[i] = 1'b0;
                d.short_cnt_q[2*i +: 2] = '0;
            end else if (short_raw[i] && !short_prev[i] && !q.short_flag_q[i]) begin
                if (q.short_cnt_q[2*i +: 2] == SHORT_RETRIES) begin
                    short_confirm[i] = 1'b1;
                    d.short_flag_q[i] = 1'b1;
                end else begin
                    d.short_cnt_q[2*i +: 2] = q.short_cnt_q[2*i +: 2] + 2'h1;
                end
            end
        end
        events[EV_SHORT_LO +: 4] = short_confirm;
        events[EV_UNDERVOLT] = d.pins_q.undervoltage & ~q.pins_q.undervoltage;

        // Bit order: ground a, ground b, supply a, supply b
        d.bridge_a_en_q = driver_en & ~d.heat_shutdown_flag_q
                          & ~d.short_flag_q[0] & ~d.short_flag_q[2];
        d.bridge_b_en_q = driver_en & ~d.heat_shutdown_flag_q
                          & ~d.short_flag_q[1] & ~d.short_flag_q[3];

        // ------
        // AXI4-Lite write channel
        // ------
        if (s_axi_awvalid && q.awready_q) begin
            d.aw_held_q = 1'b1;
            d.awaddr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready_q) begin
            d.w_held_q = 1'b1;
            d.wdata_q = s_axi_wdata;
            d.wstrb_q = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bvalid_q = 1'b0;
        end
        wr_fire = q.aw_held_q && q.w_held_q && !q.bvalid_q;
        if (wr_fire) begin
            ok = 1'b1;
            d.aw_held_q = 1'b0;
            d.w_held_q = 1'b0;
            d.bvalid_q = 1'b1;
            unique case (q.awaddr_q)
                ADDR_GLOBAL_CONFIG: begin
                    if (q.wstrb_q[0]) begin
                        d.global_config_q = q.wdata_q[4:0];
                    end
                end
                ADDR_GENERATOR_VELOCITY: begin
                    for (int b = 0; b < 3; b++) begin
                        if (q.wstrb_q[b]) begin
                            d.generator_velocity_q[8*b +: 8] = q.wdata_q[8*b +: 8];
                        end
                    end
                end
                ADDR_EVENT_CLEAR: begin
                    if (q.wstrb_q[0]) begin
                        wclear = q.wdata_q[7:0];
                    end
                end
                ADDR_EVENT_ENABLE: begin
                    if (q.wstrb_q[0]) begin
                        d.event_enable_q = q.wdata_q[7:0];
                    end
                end
                ADDR_MEASURED_STEP_PERIOD, ADDR_MICROSTEP_POSITION_COUNT,
                ADDR_DRIVER_STATUS, ADDR_EVENT_STATUS: begin
                    ok = 1'b1;
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
            d.bresp_q = ok ? RESP_OKAY : RESP_SLVERR;
        end
        d.awready_q = ~d.aw_held_q & ~d.bvalid_q;
        d.wready_q = ~d.w_held_q & ~d.bvalid_q;

        // Sticky events: a new event wins over a clear in the same cycle
        d.event_status_q = (q.event_status_q & ~wclear) | events;
        d.irq_q = |(d.event_status_q & d.event_enable_q);

        // ------
        // AXI4-Lite read channel
        // ------
        if (s_axi_rvalid && s_axi_rready) begin
            d.rvalid_q = 1'b0;
        end
        if (s_axi_arvalid && q.arready_q) begin
            d.rvalid_q = 1'b1;
            d.rresp_q = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_GLOBAL_CONFIG: rd = {27'h0, q.global_config_q};
                ADDR_GENERATOR_VELOCITY: rd = {{8{q.generator_velocity_q[23]}}, q.generator_velocity_q};
                ADDR_MEASURED_STEP_PERIOD: rd = {12'h000, q.measured_step_period_q};
                ADDR_MICROSTEP_POSITION_COUNT: rd = {22'h0, q.microstep_position_count_q};
                ADDR_DRIVER_STATUS: rd = {23'h000000, q.bridge_b_en_q, q.bridge_a_en_q, p.undervoltage,
                                          q.short_flag_q, prewarn, q.heat_shutdown_flag_q};
                ADDR_EVENT_STATUS: rd = {24'h0, q.event_status_q};
                ADDR_EVENT_CLEAR: rd = 32'h00000000;
                ADDR_EVENT_ENABLE: rd = {24'h0, q.event_enable_q};
                default: begin
                    rd = 32'h00000000;
                    d.rresp_q = RESP_SLVERR;
                end
            endcase
            d.rdata_q = rd;
        end
        d.arready_q = ~d.rvalid_q;

        // ------
        // Synchronous reset
        // ------
        if (!aresetn) begin
            d = '0;
            d.global_config_q = GLOBAL_CONFIG_RESET;
            d.generator_velocity_q = VELOCITY_RESET;
            d.microstep_position_count_q = MSCOUNT_RESET;
            d.event_enable_q = EVENT_ENABLE_RESET;
            d.otp_sel_q = TSEL_143_PW120;
            d.index_q = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    // ------
    // Outputs, all straight from the state record
    // ------
    assign s_axi_awready = q.awready_q;
    assign s_axi_wready = q.wready_q;
    assign s_axi_bvalid = q.bvalid_q;
    assign s_axi_bresp = q.bresp_q;
    assign s_axi_arready = q.arready_q;
    assign s_axi_rvalid = q.rvalid_q;
    assign s_axi_rdata = q.rdata_q;
    assign s_axi_rresp = q.rresp_q;
    assign index_out = q.index_q;
    assign bridge_a_enable = q.bridge_a_en_q;
    assign bridge_b_enable = q.bridge_b_en_q;
    assign irq = q.irq_q;

endmodule

`default_nettype wire

// ### design/stepper_pkg.sv
/*
 * Shared constants and types for the stepper index, velocity and fault block:
 * register offsets, field positions, reset values, threshold codes and the
 * packed state record of the block.
 * Assumes a single 25 MHz clock domain and a 32-bit AXI4-Lite register bus.
 */
package stepper_pkg;

    // ------
    // Register map (byte addresses)
    // ------
    localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_GENERATOR_VELOCITY = 8'h04;
    localparam logic [7:0] ADDR_MEASURED_STEP_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_MICROSTEP_POSITION_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_DRIVER_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h14;
    localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h18;
    localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h1C;

    // ------
    // Field positions and reset values
    // ------
    localparam int CFG_INDEX_STEP = 0;
    localparam int CFG_DRIVER_ENABLE = 1;
    localparam int CFG_TEMP_SERIAL = 2;
    localparam int CFG_TEMP_SEL_LO = 3;
    localparam logic [4:0] GLOBAL_CONFIG_RESET = 5'h00;
    localparam logic [23:0] VELOCITY_RESET = 24'h000000;
    localparam logic [9:0] MSCOUNT_RESET = 10'h000;
    localparam logic [19:0] PERIOD_MAX = 20'hFFFFF;
    localparam logic [7:0] EVENT_ENABLE_RESET = 8'h00;

    // Event bit positions (status, clear and enable share this layout)
    localparam int EV_SHUTDOWN = 0;
    localparam int EV_PREWARN = 1;
    localparam int EV_SHORT_LO = 2;
    localparam int EV_UNDERVOLT = 6;
    localparam int EV_INDEX = 7;

    // Short detections seen before a confirm: first one plus two retries; the third retry confirms
    localparam logic [1:0] SHORT_RETRIES = 2'h3;

    // ------
    // Temperature setting codes; comparator inputs index 120/143/150/157
    // ------
    localparam logic [1:0] TSEL_143_PW120 = 2'h0;
    localparam logic [1:0] TSEL_150_PW120 = 2'h1;
    localparam logic [1:0] TSEL_150_PW143 = 2'h2;
    localparam logic [1:0] TSEL_157_PW143 = 2'h3;
    localparam int T120 = 0;
    localparam int T143 = 1;
    localparam int T150 = 2;
    localparam int T157 = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------
    // Carriers
    // ------
    typedef struct packed {
        logic [3:0] temp_above;     // 157,150,143,120 comparators
        logic [1:0] ground_short;   // b,a raw detections
        logic [1:0] supply_short;   // b,a raw detections
        logic undervoltage;
        logic dir;
        logic step;
    } pins_s;

    localparam int PIN_W = $bits(pins_s);

    typedef struct packed {
        // Pin synchronisers and agreed values
        logic [PIN_W-1:0] sync1_q;
        logic [PIN_W-1:0] sync2_q;
        logic [PIN_W-1:0] sync3_q;
        pins_s pins_q;
        // Configuration
        logic otp_taken_q;
        logic [1:0] otp_sel_q;
        logic [4:0] global_config_q;
        logic [23:0] generator_velocity_q;
        // Motion
        logic half_tick_q;
        logic [22:0] phase_acc_q;
        logic [9:0] microstep_position_count_q;
        logic [19:0] period_cnt_q;
        logic [19:0] measured_step_period_q;
        logic index_q;
        // Protection
        logic heat_shutdown_flag_q;
        logic [3:0] short_flag_q;   // supply b,a ; ground b,a
        logic [7:0] short_cnt_q;    // 2 bits per flag
        logic bridge_a_en_q;
        logic bridge_b_en_q;
        // Events
        logic [7:0] event_status_q;
        logic [7:0] event_enable_q;
        logic irq_q;
        // AXI4-Lite
        logic awready_q;
        logic wready_q;
        logic aw_held_q;
        logic w_held_q;
        logic [7:0] awaddr_q;
        logic [31:0] wdata_q;
        logic [3:0] wstrb_q;
        logic bvalid_q;
        logic [1:0] bresp_q;
        logic arready_q;
        logic rvalid_q;
        logic [31:0] rdata_q;
        logic [1:0] rresp_q;
    } state_s;

endpackage

// ### bench/stepper_pins_model.sv
/* Motor-side model: thermal comparators, short detectors, undervoltage, step and dir.
   Assumes one bench process calls its tasks just after a rising edge. */
`timescale 1ns/100ps
`default_nettype none
module stepper_pins_model
    import stepper_pkg::*;
(
    input wire logic aclk,
    output var pins_s pins
);
    // ------
    // Tasks
    // ------
    initial pins = '0;
    // Comparators are monotonic: level n raises the n lowest thresholds
    task automatic heat(input int n);
        @(posedge aclk);
        pins.temp_above <= 4'((1 << n) - 1);
        repeat (12) @(posedge aclk);
    endtask
    // Pulse outlasts the synchroniser, so it is seen once; idx 0..3 = gnd a,b, sup a,b
    task automatic short_pulse(input int idx);
        @(posedge aclk);
        {pins.supply_short, pins.ground_short} <= 4'(1 << idx);
        repeat (6) @(posedge aclk);
        {pins.supply_short, pins.ground_short} <= 4'h0;
        repeat (6) @(posedge aclk);
    endtask
    // Dir settles an edge before step; steps come every 8 clocks
    task automatic step(input logic d);
        @(posedge aclk);
        pins.dir <= d;
        @(posedge aclk);
        pins.step <= 1'b1;
        repeat (4) @(posedge aclk);
        pins.step <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic uv(input logic u);
        @(posedge aclk);
        pins.undervoltage <= u;
        repeat (8) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ### bench/stepper_index_velocity_and_fault_logic_assertions.sv
/* Checker for the stepper block, bound to its top.
   Sees only the block's ports. */
`timescale 1ns/100ps
`default_nettype none
module stepper_checker
    import stepper_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire pins_s pins,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic index_out,
    input wire logic bridge_a_enable,
    input wire logic bridge_b_enable,
    input wire logic irq
);
    // ------
    // Properties
    // ------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write late");
    ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
    arready_low_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
    reset_state_a: assert property ($rose(aresetn) |-> index_out && !irq && !bridge_a_enable && !bridge_b_enable)
        else $error("bad reset state");
    heat_off_a: assert property (pins.temp_above[T157] [*8] |-> !bridge_a_enable && !bridge_b_enable)
        else $error("bridge on while hot");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($fell(bridge_a_enable) && bridge_b_enable);
    cover property ($rose(index_out));
endmodule
bind stepper_index_velocity_and_fault_logic stepper_checker i_chk (.*);
`default_nettype wire

// ### bench/stepper_index_velocity_and_fault_logic_tb_top.sv
/* Testbench top: register bus master, motor-side model and scenarios.
   Assumes the checker is bound to the block. */
`timescale 1ns/100ps
`default_nettype none
module stepper_index_velocity_and_fault_logic_tb_top
    import stepper_pkg::*;
;
    // ------
    // Signals
    // ------
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [1:0] otp_temp_sel = 2'h0, s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic index_out, bridge_a_enable, bridge_b_enable, irq;
    logic [9:0] a;
    pins_s pins;
    int miscompares = 0, cmp_count = 0, n;
    always #20 aclk = ~aclk;
    stepper_index_velocity_and_fault_logic i_dut (.*);
    stepper_pins_model i_pins (.*);
    // ------
    // Bus and check tasks
    // ------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    // Ready is raised only after valid is seen, so the hold of the answer is exercised
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        s_axi_awaddr <= adr;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] adr);
        s_axi_araddr <= adr;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] otp);
        aresetn <= 1'b0;
        otp_temp_sel <= otp;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask
    // Count advance over 803 clocks: 100.4 steps at 2^21
    task automatic span(input logic [31:0] vel);
        wr(ADDR_GENERATOR_VELOCITY, vel);
        rd(ADDR_MICROSTEP_POSITION_COUNT);
        a = v[9:0];
        repeat (800) @(posedge aclk);
        rd(ADDR_MICROSTEP_POSITION_COUNT);
        a = 10'(v[9:0] - a);
    endtask
    task automatic heat_chk(input int lvl, input logic [1:0] e);
        i_pins.heat(lvl);
        check(32'({bridge_a_enable, bridge_b_enable}), 32'(e), "bridges");
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        rd(ADDR_GLOBAL_CONFIG);
        check(v, 32'h0, "config");
        check(32'(index_out), 32'h1, "marker");
        wr(8'h20, 32'h1);
        check(32'(resp), 32'(RESP_SLVERR), "unmapped");
        rd(8'h20);
        check({v[29:0], resp}, 32'(RESP_SLVERR), "unmapped read");
    endtask
    task automatic t_ext;
        repeat (4) i_pins.step(1'b1);
        rd(ADDR_MICROSTEP_POSITION_COUNT);
        check(v, 32'h3FC, "down wrap");
        repeat (4) i_pins.step(1'b0);
        rd(ADDR_MICROSTEP_POSITION_COUNT);
        check({v[30:0], index_out}, 32'h1, "up wrap");
        wr(ADDR_GLOBAL_CONFIG, 32'h1);
        repeat (2) @(posedge aclk);
        for (int k = 0; k < 2; k++) begin
            a[0] = index_out;
            i_pins.step(1'b0);
            repeat (4) @(posedge aclk);
            check(32'(index_out ^ a[0]), 32'h1, "toggle");
        end
        wr(ADDR_GLOBAL_CONFIG, 32'h0);
    endtask
    task automatic t_gen;
        for (int k = 19; k < 22; k++) wr(ADDR_GENERATOR_VELOCITY, 32'(1 << k));
        repeat (50) @(posedge aclk);
        rd(ADDR_MEASURED_STEP_PERIOD);
        check(v, 32'h8, "period");
        span(32'h00200000);
        check(32'(a inside {10'h064, 10'h065}), 32'h1, "rate up");
        while (!index_out) @(posedge aclk);
        while (index_out) @(posedge aclk);
        n = 0;
        repeat (12288) begin
            @(posedge aclk);
            n += int'(index_out);
        end
        check(32'(n), 32'h8, "marker per period");
        span(32'h00E00000);
        check(32'(a inside {10'h39B, 10'h39C}), 32'h1, "rate down");
        span(32'h0);
        check(32'(a), 32'h0, "idle");
    endtask
    task automatic t_heat;
        int sd[4] = '{2, 3, 3, 4};
        int pw[4] = '{1, 1, 2, 2};
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_GLOBAL_CONFIG, c == 0 ? 32'h2 : 32'(6 + c * 8));
            heat_chk(sd[c] - 1, 2'h3);
            heat_chk(sd[c], 2'h0);
            heat_chk(pw[c], 2'h0);
            heat_chk(pw[c] - 1, 2'h3);
        end
        for (int r = 1; r < 4; r++) begin
            do_reset(2'(r));
            wr(ADDR_GLOBAL_CONFIG, 32'h2);
            heat_chk(2, r < 3 ? 2'h3 : 2'h0);
            heat_chk(0, 2'h3);
        end
    endtask
    task automatic t_short;
        logic [2:0] e;
        for (int i = 0; i < 4; i++) begin
            e = i[0] ? 3'h2 : 3'h1;
            wr(ADDR_EVENT_ENABLE, 32'(1 << (EV_SHORT_LO + i)));
            wr(ADDR_GLOBAL_CONFIG, 32'h2);
            repeat (3) i_pins.short_pulse(i);
            check(32'({irq, bridge_a_enable, bridge_b_enable}), 32'h3, "retry");
            i_pins.short_pulse(i);
            check(32'({irq, bridge_a_enable, bridge_b_enable}), 32'(e + 3'h4), "confirm");
            rd(ADDR_DRIVER_STATUS);
            check(32'(v[5:2]), 32'(1 << i), "short flag");
            wr(ADDR_EVENT_CLEAR, 32'hFF);
            repeat (2) @(posedge aclk);
            check(32'({irq, bridge_a_enable, bridge_b_enable}), 32'(e), "cleared, still off");
            wr(ADDR_GLOBAL_CONFIG, 32'h0);
        end
        wr(ADDR_GLOBAL_CONFIG, 32'h2);
        i_pins.uv(1'b1);
        rd(ADDR_EVENT_STATUS);
        check(32'({v[EV_UNDERVOLT], irq, bridge_a_enable, bridge_b_enable}), 32'hB, "undervoltage masked");
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        @(posedge aclk);
        do_reset(2'h0);
        t_regs;
        t_ext;
        t_gen;
        t_heat;
        t_short;
        summarize;
    end
    // Whole run needs about 23000 clocks
    initial begin
        repeat (80000) @(posedge aclk);
        miscompares++;
        $display("wrong value at %0t: timeout", $time);
        summarize;
    end
endmodule
`default_nettype wire
